/* rtl/sgps_supervisor.sv */
// Function
// RQ1: Sample both contacts continuously, derive position
// RQ2: Report code 0..3 plus four flags
// RQ3: Close command starts close timer, intermediate
// RQ4: Confirmed in time: set flag, drop intermediate
// RQ5: Timer expiry unconfirmed: faulted, code 3
// RQ6: Open command supervised same with open timer
// RQ7: Both equal while timing: intermediate, code 0
// RQ8: Both equal while idle: faulted, code 3
// RQ9: Contacts 01 open code 1, 10 closed 2
// RQ10: Close output lasts at most close time
// RQ11: Open output lasts at most open time
// RQ12: Close and open times set independently
// RQ13: Plug pulled reports withdrawn state
// RQ14: Withdrawn forces validated position to open
// RQ15: Withdrawn breaker rejects position override
// RQ16: User interlock blocks withdrawing closed breaker (not implemented: no interlock signal exists, withdrawal is only reported)
// RQ17: At least one auxiliary contact wired
// RQ18: Single contact: reduced supervision, no faults
// RQ19: Optionally route protection commands to relays
// RQ20: Fixed tick timers, restart on command
`timescale 1ns/1ps
module sgps_supervisor
   import sgps_pkg::*;
#(
   parameter int P_TICK_CYC = TICK_CYC
) (
   // Clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   // Wishbone slave
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [7:0]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   output logic      [31:0] O_WB_DAT,
   output logic             O_WB_ACK,
   // Switchgear contacts and plug
   input  wire logic        I_AUX_CLOSED,
   input  wire logic        I_AUX_OPEN,
   input  wire logic        I_PLUG_REMOVED,
   // Protection commands
   input  wire logic        I_PROT_CLOSE,
   input  wire logic        I_PROT_OPEN,
   // Command relays
   output logic             O_CMD_CLOSE,
   output logic             O_CMD_OPEN,
   // Validated position
   output logic      [1:0]  O_POS_CODE,
   output logic             O_POS_CLOSED,
   output logic             O_POS_OPEN,
   output logic             O_POS_INTERM,
   output logic             O_POS_FAULT,
   output logic             O_WITHDRAWN
);

   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(P_TICK_CYC - 1);

   typedef struct packed {
      sgps_move_t        mv;
      logic [TICK_W-1:0] tick;
      logic [TIME_W-1:0] elapsed;
      logic              cmd_close;
      logic              cmd_open;
      logic              fault;
      logic [CTRL_W-1:0] ctrl;
      logic [TIME_W-1:0] t_close;
      logic [TIME_W-1:0] t_open;
      logic              prot_close_prev;
      logic              prot_open_prev;
      logic              ack;
      logic [31:0]       rdat;
      logic [1:0]        code;
      logic              withdrawn;
   } sgps_state_t;

   sgps_state_t st_q;
   sgps_state_t st_d;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [2:0] pin_lvl;

   // Plug resets to inserted; contacts to both low
   sgps_sync3 #(
      .W       (3),
      .RST_VAL (3'h0)
   ) u_sync (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_pin   ({I_PLUG_REMOVED, I_AUX_OPEN, I_AUX_CLOSED}),
      .o_lvl   (pin_lvl)
   );

   logic aux_c;
   logic aux_o;
   logic plug_out;

   assign aux_c    = pin_lvl[0];
   assign aux_o    = pin_lvl[1];
   assign plug_out = pin_lvl[2];

   // ****************************************************************
   // Effective contacts and raw position
   // ****************************************************************
   logic       eff_c;
   logic       eff_o;
   logic       wired_c;
   logic       wired_o;
   logic [1:0] pos_raw;
   logic       running;

   always_comb begin
      running = (st_q.mv != MV_IDLE);
      wired_c = st_q.ctrl[CTRL_WC];
      wired_o = st_q.ctrl[CTRL_WO];
      if (plug_out) begin
         // Override bits are ignored while the plug is out
         eff_c   = 1'b0; // RQ14 RQ15
         eff_o   = 1'b1; // RQ14
         wired_c = 1'b1;
         wired_o = 1'b1;
      end else if (st_q.ctrl[CTRL_OVEN]) begin
         eff_c = st_q.ctrl[CTRL_OVC];
         eff_o = st_q.ctrl[CTRL_OVO];
      end else begin
         eff_c = aux_c; // RQ1
         eff_o = aux_o; // RQ1
      end

      if (wired_c && wired_o) begin
         if (eff_c != eff_o) begin
            pos_raw = eff_c ? POS_CLOSED : POS_OPEN; // RQ9
         end else begin
            pos_raw = running ? POS_INTERM : POS_FAULT; // RQ7 RQ8
         end
      end else if (wired_c) begin
         // Missing contact taken as the complement
         pos_raw = eff_c ? POS_CLOSED : POS_OPEN; // RQ18
      end else if (wired_o) begin
         pos_raw = eff_o ? POS_OPEN : POS_CLOSED; // RQ18
      end else begin
         // No contact wired: nothing can be validated
         pos_raw = POS_FAULT; // RQ17
      end
   end

   // ****************************************************************
   // Command sources
   // ****************************************************************
   logic req;
   logic wr;
   logic sw_close;
   logic sw_open;
   logic pr_close;
   logic pr_open;
   logic start_close;
   logic start_open;

   always_comb begin
      req      = I_WB_CYC && I_WB_STB && !st_q.ack;
      wr       = req && I_WB_WE;
      sw_close = wr && (I_WB_ADR == ADR_CMD) && I_WB_SEL[0] && I_WB_DAT[CMD_CLOSE];
      sw_open  = wr && (I_WB_ADR == ADR_CMD) && I_WB_SEL[0] && I_WB_DAT[CMD_OPEN];
      // Protection only drives the relays when routing is enabled
      pr_close = st_q.ctrl[CTRL_ROUTE] && I_PROT_CLOSE && !st_q.prot_close_prev; // RQ19
      pr_open  = st_q.ctrl[CTRL_ROUTE] && I_PROT_OPEN && !st_q.prot_open_prev;   // RQ19
      // Open wins when both arrive together: tripping is the safe side
      start_open  = sw_open || pr_open;
      start_close = (sw_close || pr_close) && !start_open;
   end

   // ****************************************************************
   // Travel supervision
   // ****************************************************************
   logic              confirm;
   logic              expired;
   logic [TIME_W-1:0] limit;

   always_comb begin
      limit   = (st_q.mv == MV_CLOSE) ? st_q.t_close : st_q.t_open; // RQ12
      confirm = ((st_q.mv == MV_CLOSE) && (pos_raw == POS_CLOSED)) ||
                ((st_q.mv == MV_OPEN) && (pos_raw == POS_OPEN));
      expired = running && (st_q.elapsed >= limit);
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_d                 = st_q;
      st_d.prot_close_prev = I_PROT_CLOSE;
      st_d.prot_open_prev  = I_PROT_OPEN;
      st_d.withdrawn       = plug_out; // RQ13

      // Fixed tick drives the travel count
      if (running) begin
         if (st_q.tick == TICK_LAST) begin
            st_d.tick    = '0;
            st_d.elapsed = st_q.elapsed + TIME_W'(1); // RQ20
         end else begin
            st_d.tick = st_q.tick + TICK_W'(1);
         end
      end

      case (st_q.mv)
         MV_IDLE: begin
         end
         MV_CLOSE,
         MV_OPEN: begin
            if (confirm) begin
               // Relay drops as soon as the new position shows
               st_d.mv        = MV_IDLE; // RQ4
               st_d.cmd_close = 1'b0;    // RQ10
               st_d.cmd_open  = 1'b0;    // RQ11
               st_d.fault     = 1'b0;
            end else if (expired) begin
               st_d.mv        = MV_IDLE;
               st_d.cmd_close = 1'b0;                      // RQ10
               st_d.cmd_open  = 1'b0;                      // RQ11
               st_d.fault     = wired_c && wired_o;        // RQ5 RQ6 RQ18
            end
         end
         default: begin
            st_d.mv        = MV_IDLE;
            st_d.cmd_close = 1'b0;
            st_d.cmd_open  = 1'b0;
         end
      endcase

      // A new command restarts the timer from zero
      if (start_close) begin
         st_d.mv        = MV_CLOSE; // RQ3
         st_d.tick      = '0;       // RQ20
         st_d.elapsed   = '0;       // RQ20
         st_d.cmd_close = 1'b1;     // RQ10
         st_d.cmd_open  = 1'b0;
         st_d.fault     = 1'b0;
      end else if (start_open) begin
         st_d.mv        = MV_OPEN;  // RQ6
         st_d.tick      = '0;       // RQ20
         st_d.elapsed   = '0;       // RQ20
         st_d.cmd_open  = 1'b1;     // RQ11
         st_d.cmd_close = 1'b0;
         st_d.fault     = 1'b0;
      end

      // Validated position code, taken from the next move state so the
      // intermediate code rises with the relay and the fault with expiry
      if (plug_out) begin
         st_d.code = POS_OPEN; // RQ14
      end else if (st_d.mv != MV_IDLE) begin
         st_d.code = POS_INTERM; // RQ3 RQ6 RQ7
      end else if (st_d.fault) begin
         st_d.code = POS_FAULT; // RQ5
      end else begin
         st_d.code = pos_raw; // RQ2 RQ4 RQ8 RQ9
      end

      // ************************************************************
      // Register access
      // ************************************************************
      st_d.ack = req;
      if (wr) begin
         case (I_WB_ADR)
            ADR_CTRL: begin
               if (I_WB_SEL[0]) begin
                  st_d.ctrl = I_WB_DAT[CTRL_W-1:0];
               end
            end
            ADR_TCLOSE: begin
               if (I_WB_SEL[0]) begin
                  st_d.t_close[7:0] = I_WB_DAT[7:0]; // RQ12
               end
               if (I_WB_SEL[1]) begin
                  st_d.t_close[15:8] = I_WB_DAT[15:8]; // RQ12
               end
            end
            ADR_TOPEN: begin
               if (I_WB_SEL[0]) begin
                  st_d.t_open[7:0] = I_WB_DAT[7:0]; // RQ12
               end
               if (I_WB_SEL[1]) begin
                  st_d.t_open[15:8] = I_WB_DAT[15:8]; // RQ12
               end
            end
            default: begin
            end
         endcase
      end

      if (req) begin
         case (I_WB_ADR)
            ADR_CTRL:   st_d.rdat = {26'h0, st_q.ctrl};
            ADR_TCLOSE: st_d.rdat = {16'h0, st_q.t_close};
            ADR_TOPEN:  st_d.rdat = {16'h0, st_q.t_open};
            ADR_STATUS: st_d.rdat = {21'h0, st_q.mv == MV_OPEN, st_q.mv == MV_CLOSE,
                                     st_q.cmd_open, st_q.cmd_close, st_q.withdrawn,
                                     st_q.code == POS_FAULT, st_q.code == POS_INTERM,
                                     st_q.code == POS_OPEN, st_q.code == POS_CLOSED,
                                     st_q.code};
            default:    st_d.rdat = 32'h0;
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_q.mv              <= MV_IDLE;
         st_q.tick            <= '0;
         st_q.elapsed         <= '0;
         st_q.cmd_close       <= 1'b0;
         st_q.cmd_open        <= 1'b0;
         st_q.fault           <= 1'b0;
         st_q.ctrl            <= CTRL_RST;
         st_q.t_close         <= TCLOSE_RST;
         st_q.t_open          <= TOPEN_RST;
         st_q.prot_close_prev <= 1'b0;
         st_q.prot_open_prev  <= 1'b0;
         st_q.ack             <= 1'b0;
         st_q.rdat            <= 32'h0;
         st_q.code            <= POS_FAULT;
         st_q.withdrawn       <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign O_WB_DAT     = st_q.rdat;
   assign O_WB_ACK     = st_q.ack;
   assign O_CMD_CLOSE  = st_q.cmd_close;
   assign O_CMD_OPEN   = st_q.cmd_open;
   assign O_POS_CODE   = st_q.code;
   assign O_POS_CLOSED = (st_q.code == POS_CLOSED);
   assign O_POS_OPEN   = (st_q.code == POS_OPEN);
   assign O_POS_INTERM = (st_q.code == POS_INTERM);
   assign O_POS_FAULT  = (st_q.code == POS_FAULT);
   assign O_WITHDRAWN  = st_q.withdrawn;

endmodule

/* rtl/sgps_pkg.sv */
package sgps_pkg;

   // ****************************************************************
   // Clock and travel tick
   // ****************************************************************
   localparam int CLK_PERIOD_NS  = 8;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYC       = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
   localparam int TICK_W         = 20;
   localparam int TIME_W         = 16;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_TCLOSE = 8'h04;
   localparam logic [7:0] ADR_TOPEN  = 8'h08;
   localparam logic [7:0] ADR_STATUS = 8'h0c;
   localparam logic [7:0] ADR_CMD    = 8'h10;

   // Control field positions
   localparam int CTRL_ROUTE = 0;
   localparam int CTRL_WC    = 1;
   localparam int CTRL_WO    = 2;
   localparam int CTRL_OVEN  = 3;
   localparam int CTRL_OVC   = 4;
   localparam int CTRL_OVO   = 5;
   localparam int CTRL_W     = 6;

   // Command field positions
   localparam int CMD_CLOSE = 0;
   localparam int CMD_OPEN  = 1;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h06;
   localparam logic [TIME_W-1:0] TCLOSE_RST = 16'h00c8;
   localparam logic [TIME_W-1:0] TOPEN_RST  = 16'h00c8;

   // ****************************************************************
   // Position codes
   // ****************************************************************
   localparam logic [1:0] POS_INTERM = 2'h0;
   localparam logic [1:0] POS_OPEN   = 2'h1;
   localparam logic [1:0] POS_CLOSED = 2'h2;
   localparam logic [1:0] POS_FAULT  = 2'h3;

   typedef enum logic [1:0] {
      MV_IDLE,
      MV_CLOSE,
      MV_OPEN
   } sgps_move_t;

endpackage

/* rtl/sgps_sync3.sv */
`timescale 1ns/1ps
module sgps_sync3
   import sgps_pkg::*;
#(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // Pins and filtered levels
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_lvl
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sgps_sync_t;

   // ****************************************************************
   // One synchroniser per pin
   // ****************************************************************
   for (genvar b = 0; b < W; b++) begin : g_bit
      sgps_sync_t st_q;
      sgps_sync_t st_d;

      always_comb begin
         st_d    = st_q;
         st_d.s1 = i_pin[b];
         st_d.s2 = st_q.s1;
         st_d.s3 = st_q.s2;
         // Only a level seen on two later stages is taken
         if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
         end
      end

      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            st_q <= {RST_VAL[b], RST_VAL[b], RST_VAL[b], RST_VAL[b]};
         end else begin
            st_q <= st_d;
         end
      end

      assign o_lvl[b] = st_q.lvl;
   end

endmodule

/* bench/sgps_monitor.sv */
`timescale 1ns/1ps
module sgps_monitor
   import sgps_pkg::*;
#(
   parameter int P_TICK_CYC = TICK_CYC
) (
   input wire logic        I_CLK,
   input wire logic        I_RST_N,
   input wire logic        I_WB_CYC,
   input wire logic        I_WB_STB,
   input wire logic        I_WB_WE,
   input wire logic [7:0]  I_WB_ADR,
   input wire logic [3:0]  I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   input wire logic [31:0] O_WB_DAT,
   input wire logic        O_WB_ACK,
   input wire logic        I_AUX_CLOSED,
   input wire logic        I_AUX_OPEN,
   input wire logic        I_PLUG_REMOVED,
   input wire logic        I_PROT_CLOSE,
   input wire logic        I_PROT_OPEN,
   input wire logic        O_CMD_CLOSE,
   input wire logic        O_CMD_OPEN,
   input wire logic [1:0]  O_POS_CODE,
   input wire logic        O_POS_CLOSED,
   input wire logic        O_POS_OPEN,
   input wire logic        O_POS_INTERM,
   input wire logic        O_POS_FAULT,
   input wire logic        O_WITHDRAWN
);
   // ********
   // Travel times mirrored from bus writes, relay on-time counters
   // ********
   logic [TIME_W-1:0] tcl_q;
   logic [TIME_W-1:0] top_q;
   logic [31:0]       ncl_q;
   logic [31:0]       nop_q;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tcl_q <= TCLOSE_RST;
         top_q <= TOPEN_RST;
         ncl_q <= '0;
         nop_q <= '0;
      end else begin
         if (O_WB_ACK && I_WB_WE && I_WB_ADR == ADR_TCLOSE) tcl_q <= I_WB_DAT[TIME_W-1:0];
         if (O_WB_ACK && I_WB_WE && I_WB_ADR == ADR_TOPEN) top_q <= I_WB_DAT[TIME_W-1:0];
         ncl_q <= O_CMD_CLOSE ? ncl_q + 32'h1 : '0;
         nop_q <= O_CMD_OPEN ? nop_q + 32'h1 : '0;
      end
   end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   flag_decode_a: assert property (O_POS_CLOSED == (O_POS_CODE == POS_CLOSED) &&
      O_POS_OPEN == (O_POS_CODE == POS_OPEN) && O_POS_INTERM == (O_POS_CODE == POS_INTERM)
      && O_POS_FAULT == (O_POS_CODE == POS_FAULT)) else $error("flags disagree with code");
   close_len_a: assert property (ncl_q <= tcl_q * P_TICK_CYC + 1)
      else $error("close relay held too long");
   open_len_a: assert property (nop_q <= top_q * P_TICK_CYC + 1)
      else $error("open relay held too long");
   close_interm_a: assert property (O_CMD_CLOSE && !O_WITHDRAWN |-> O_POS_INTERM)
      else $error("not intermediate while closing");
   open_interm_a: assert property (O_CMD_OPEN && !O_WITHDRAWN |-> O_POS_INTERM)
      else $error("not intermediate while opening");
   plug_on_a: assert property (I_PLUG_REMOVED [*6] |-> O_WITHDRAWN)
      else $error("withdrawn not reported");
   plug_off_a: assert property (!I_PLUG_REMOVED [*6] |-> !O_WITHDRAWN)
      else $error("withdrawn reported without plug");
   plug_open_a: assert property (O_WITHDRAWN && $past(O_WITHDRAWN) |-> O_POS_CODE == POS_OPEN)
      else $error("withdrawn breaker not open");
   idle_fault_a: assert property ((!O_CMD_CLOSE && !O_CMD_OPEN && !O_WITHDRAWN &&
      I_AUX_CLOSED == I_AUX_OPEN) [*6] |-> O_POS_FAULT) else $error("equal contacts not faulted");
   open_valid_a: assert property ((!O_CMD_CLOSE && !O_CMD_OPEN && !O_POS_FAULT &&
      !I_AUX_CLOSED && I_AUX_OPEN) [*6] |-> O_POS_OPEN) else $error("open contacts not open");
endmodule

/* bench/sgps_gear_model.sv */
`timescale 1ns/1ps
module sgps_gear_model (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Relay coils and test knobs
   input  wire logic       i_coil_close,
   input  wire logic       i_coil_open,
   input  wire logic       i_stuck,
   input  wire logic [7:0] i_delay,
   // Auxiliary contacts
   output logic            o_aux_closed,
   output logic            o_aux_open
);
   logic       mv_q;
   logic       tgt_q;
   logic [7:0] cnt_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mv_q <= 1'b0;
         tgt_q <= 1'b0;
         cnt_q <= '0;
         o_aux_closed <= 1'b0;
         o_aux_open <= 1'b1;
      end else if (!mv_q && ((i_coil_open && !(o_aux_open && !o_aux_closed)) ||
                             (i_coil_close && !(o_aux_closed && !o_aux_open)))) begin
         // Both contacts break in travel; a jammed drive shows both made
         mv_q <= 1'b1;
         tgt_q <= !i_coil_open;
         cnt_q <= '0;
         o_aux_closed <= i_stuck;
         o_aux_open <= i_stuck;
      end else if (mv_q && i_stuck) begin
         mv_q <= i_coil_close | i_coil_open;
      end else if (mv_q) begin
         cnt_q <= cnt_q + 8'h1;
         if (cnt_q == i_delay) begin
            mv_q <= 1'b0;
            o_aux_closed <= tgt_q;
            o_aux_open <= !tgt_q;
         end
      end
   end
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb
   import sgps_pkg::*;
;
   logic clk, rst_n, cyc, stb, we, aux_c, aux_o, plug, pc, po, stuck;
   logic cmd_c, cmd_o, ack, fc, fo, fi, ff, wd;
   logic [7:0]  adr;
   logic [7:0]  delay;
   logic [3:0]  sel;
   logic [1:0]  code;
   logic [31:0] dat_w, dat_r;
   int num_errors = 0;
   int checked = 0;
   sgps_supervisor #(.P_TICK_CYC(4)) u_sgps_supervisor (.I_CLK(clk), .I_RST_N(rst_n),
      .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
      .I_WB_DAT(dat_w), .O_WB_DAT(dat_r), .O_WB_ACK(ack), .I_AUX_CLOSED(aux_c),
      .I_AUX_OPEN(aux_o), .I_PLUG_REMOVED(plug), .I_PROT_CLOSE(pc), .I_PROT_OPEN(po),
      .O_CMD_CLOSE(cmd_c), .O_CMD_OPEN(cmd_o), .O_POS_CODE(code), .O_POS_CLOSED(fc),
      .O_POS_OPEN(fo), .O_POS_INTERM(fi), .O_POS_FAULT(ff), .O_WITHDRAWN(wd));
   sgps_gear_model u_sgps_gear_model (.i_clk(clk), .i_rst_n(rst_n), .i_coil_close(cmd_c),
      .i_coil_open(cmd_o), .i_stuck(stuck), .i_delay(delay), .o_aux_closed(aux_c),
      .o_aux_open(aux_o));
   // ********
   // Bus tasks and checks
   // ********
   task automatic final_report();
      if (num_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) chk(32'h0, 32'h1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(q, e);
      // Pins must agree with the status word while nothing is changing
      if (a == ADR_STATUS) chk({23'h0, cmd_o, cmd_c, wd, ff, fi, fo, fc, code}, e & 32'h1ff);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      wt(3000);
      num_errors++;
      final_report();
   end
   initial begin
      {rst_n, cyc, stb, we, plug, pc, po, stuck} = '0;
      adr = '0;
      sel = 4'hf;
      dat_w = '0;
      delay = 8'h0a;
      wt(5);
      rst_n <= 1'b1;
      wt(8);
      rd(ADR_CTRL, 32'h6);
      rd(ADR_TCLOSE, 32'hc8);
      rd(ADR_TOPEN, 32'hc8);
      wr(ADR_TCLOSE, 32'ha);
      wr(ADR_TOPEN, 32'h6);
      wr(8'h14, 32'hff);
      rd(8'h14, 32'h0);
      rd(ADR_TCLOSE, 32'ha);
      rd(ADR_TOPEN, 32'h6);
      rd(ADR_STATUS, 32'h9);
      wr(ADR_CMD, 32'h1);
      rd(ADR_STATUS, 32'h290);
      wt(40);
      rd(ADR_STATUS, 32'h6);
      stuck <= 1'b1;
      wr(ADR_CMD, 32'h2);
      rd(ADR_STATUS, 32'h510);
      wt(40);
      rd(ADR_STATUS, 32'h23);
      stuck <= 1'b0;
      wr(ADR_CMD, 32'h2);
      wt(40);
      rd(ADR_STATUS, 32'h9);
      wr(ADR_CTRL, 32'h7);
      delay <= 8'h02;
      pc <= 1'b1;
      wt(1);
      pc <= 1'b0;
      wt(30);
      rd(ADR_STATUS, 32'h6);
      po <= 1'b1;
      wt(1);
      po <= 1'b0;
      wt(30);
      rd(ADR_STATUS, 32'h9);
      plug <= 1'b1;
      wt(8);
      rd(ADR_STATUS, 32'h49);
      wr(ADR_CMD, 32'h1);
      wt(45);
      rd(ADR_STATUS, 32'h49);
      wr(ADR_CTRL, 32'h1f);
      wt(4);
      rd(ADR_STATUS, 32'h49);
      final_report();
   end
endmodule
bind sgps_supervisor sgps_monitor #(.P_TICK_CYC(P_TICK_CYC)) u_sgps_monitor (.*);
